// ### shared/exec_pkg.sv
/*
 * constants for the low-power entry and borrow-subtract execution block:
 * opcode patterns, operand field positions, phase codes, flag reset values.
 * assumes an 8-bit core with a 16-bit instruction word.
 */
`default_nettype none
package exec_pkg;
   localparam int          DATA_W        = 8;
   localparam int          INSN_W        = 16;
   localparam int          BANK_W        = 4;
   // full-word pattern of the low-power entry instruction
   localparam logic [15:0] SLEEP_WORD    = 16'h0003;
   // borrow-subtract: top six bits fixed, then d, a, 8-bit f
   localparam logic [5:0]  SUBB_OPC      = 6'h15;
   localparam int          OPC_HI        = 15;
   localparam int          OPC_LO        = 10;
   localparam int          DEST_BIT      = 9;
   localparam int          BANK_BIT      = 8;
   localparam int          FILE_HI       = 7;
   // indexed literal offset applies to file addresses up to this value
   localparam logic [7:0]  INDEXED_MAX   = 8'h5F;
   // access bank: offsets below 0x60 map to bank 0, the rest to the top bank
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
   localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
   localparam logic        TIMEOUT_RST   = 1'b1;
   localparam logic        POWERDOWN_RST = 1'b1;
   // instruction clock phases, one-hot
   typedef enum logic [3:0] {
      PH_Q1 = 4'b0001,
      PH_Q2 = 4'b0010,
      PH_Q3 = 4'b0100,
      PH_Q4 = 4'b1000
   } phase_t;
endpackage
`default_nettype wire

// ### hw/sleep_and_borrow_subtract_exec.sv
/*
 * execution logic for the low-power entry instruction and the subtract
 * with borrow instruction of an 8-bit core, stepped by four phases.
 * assumes the core fetch stage presents insnWord with insnValid at Q1 and
 * supplies fileData (operand already read) by Q3; indexBase is the indexed
 * base pointer; wake events come from outside as one-cycle pulses.
 */
// How it works
// - low-power entry sets the time-out flag, clears watchdog+postscaler.
// - low-power entry sleeps, oscillator off, at phase four of its cycle.
// - a wake-up by watchdog expiry clears the time-out flag.
// - subtract result goes to acc if dest bit clear, else back to file.
// - low-power entry also clears the power-down flag.
// - bank bit clear uses access bank, set takes bank select register.
// - bank bit clear, extended set on, address up to 95: indexed mode.
`default_nettype none
module sleep_and_borrow_subtract_exec (
   input  wire logic                        ref_clk,          // core clock
   input  wire logic                        reset,            // async, high
   input  wire logic [exec_pkg::INSN_W-1:0] insnWord,         // instruction
   input  wire logic                        insnValid,        // word is live
   input  wire logic [exec_pkg::DATA_W-1:0] fileData,         // operand of f
   input  wire logic [exec_pkg::BANK_W-1:0] bank_select_reg,  // current bank
   input  wire logic                        extendedEn,       // extended set
   input  wire logic [exec_pkg::DATA_W-1:0] indexBase,        // indexed base
   input  wire logic                        wakeEvent,        // wake pulse
   input  wire logic                        wakeWatchdog,     // watchdog wake
   output logic      [exec_pkg::DATA_W-1:0] accOut,           // accumulator
   output logic      [11:0]                 fileAddr,         // file address
   output logic      [exec_pkg::DATA_W-1:0] fileWrData,       // data to f
   output logic                             fileWrEn,         // write strobe
   output logic                             timeout_flag,     // time-out
   output logic                             powerdown_flag,   // power-down
   output logic                             carryFlag,        // carry
   output logic                             digit_carry_flag, // digit carry
   output logic                             zeroFlag,         // zero
   output logic                             overflow_flag,    // overflow
   output logic                             negFlag,          // negative
   output logic                             watchdogClr,      // clear watchdog
   output logic                             oscHalt,          // osc stopped
   output logic                             sleeping          // in sleep
);
   import exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // phase sequencer: runs only while awake, so sleep freezes the core
   phase_t phase_r;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         phase_r <= PH_Q1;
      end else if (!sleeping) begin
         case (phase_r)
            PH_Q1:   phase_r <= PH_Q2;
            PH_Q2:   phase_r <= PH_Q3;
            PH_Q3:   phase_r <= PH_Q4;
            PH_Q4:   phase_r <= PH_Q1;
            default: phase_r <= PH_Q1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode at Q1, held for the rest of the cycle
   logic [INSN_W-1:0] insn_r;
   logic              isSleep_r;
   logic              isSubb_r;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         insn_r    <= '0;
         isSleep_r <= 1'b0;
         isSubb_r  <= 1'b0;
      end else if (phase_r == PH_Q1 && !sleeping) begin
         insn_r    <= insnWord;
         isSleep_r <= insnValid && insnWord == SLEEP_WORD;
         isSubb_r  <= insnValid && insnWord[OPC_HI:OPC_LO] == SUBB_OPC;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operand address resolution during Q2
   logic [7:0]  fOff;
   logic        bankSel;
   logic [11:0] addr_nxt;
   assign fOff    = insn_r[FILE_HI:0];
   assign bankSel = insn_r[BANK_BIT];
   always_comb begin
      if (bankSel) begin
         addr_nxt = {bank_select_reg, fOff};
      end else if (extendedEn && fOff <= INDEXED_MAX) begin
         addr_nxt = {4'h0, 8'(indexBase + fOff)};
      end else if (fOff < ACCESS_SPLIT) begin
         addr_nxt = {4'h0, fOff};
      end else begin
         addr_nxt = {ACCESS_HI_BNK, fOff};
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fileAddr <= '0;
      end else if (phase_r == PH_Q2 && isSubb_r) begin
         fileAddr <= addr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // subtract with borrow: acc - f - !C, carry means "no borrow"
   logic [8:0] diff;
   logic [4:0] lowDiff;
   logic [7:0] res;
   logic       ovNxt;
   assign diff    = {1'b0, accOut} - {1'b0, fileData} - 9'(!carryFlag);
   assign lowDiff = {1'b0, accOut[3:0]} - {1'b0, fileData[3:0]}
                    - 5'(!carryFlag);
   assign res     = diff[7:0];
   // signed overflow: operands of opposite sign and sign of result wrong
   assign ovNxt   = (accOut[7] ^ fileData[7]) & (accOut[7] ^ res[7]);

   // results and flags written together at Q4 so they stay coherent
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         accOut           <= '0;
         fileWrData       <= '0;
         carryFlag        <= 1'b0;
         digit_carry_flag <= 1'b0;
         zeroFlag         <= 1'b0;
         overflow_flag    <= 1'b0;
         negFlag          <= 1'b0;
      end else if (phase_r == PH_Q4 && isSubb_r) begin
         if (insn_r[DEST_BIT]) begin
            fileWrData <= res;
         end else begin
            accOut <= res;
         end
         carryFlag        <= !diff[8];
         digit_carry_flag <= !lowDiff[4];
         zeroFlag         <= res == 8'h00;
         overflow_flag    <= ovNxt;
         negFlag          <= res[7];
      end
   end

   // write strobe is a one-phase pulse in the Q1 after Q4 only when dest is f
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fileWrEn <= 1'b0;
      end else begin
         fileWrEn <= phase_r == PH_Q4 && isSubb_r && insn_r[DEST_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // low-power entry and wake-up
   logic goSleep;
   assign goSleep = phase_r == PH_Q4 && isSleep_r && !sleeping;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sleeping <= 1'b0;
         oscHalt  <= 1'b0;
      end else if (goSleep) begin
         sleeping <= 1'b1;
         oscHalt  <= 1'b1;
      end else if (sleeping && wakeEvent) begin
         sleeping <= 1'b0;
         oscHalt  <= 1'b0;
      end
   end

   // watchdog clear is a one-cycle pulse on entry
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         watchdogClr <= 1'b0;
      end else begin
         watchdogClr <= goSleep;
      end
   end

   // status flags; the wake clear is only taken while asleep, so it
   // cannot collide with the set at entry
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         timeout_flag   <= TIMEOUT_RST;
         powerdown_flag <= POWERDOWN_RST;
      end else if (goSleep) begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b0;
      end else if (sleeping && wakeEvent && wakeWatchdog) begin
         timeout_flag   <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks; one clock domain, so clock and reset are given once here
   default clocking chkClk @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence sleepDecoded_s;
      phase_r == PH_Q4 && isSleep_r && !sleeping;
   endsequence
   sequence sleepEntered_s;
      sleeping && oscHalt && timeout_flag && !powerdown_flag;
   endsequence
   sequence clearPulse_s;
      watchdogClr ##1 !watchdogClr;
   endsequence

   sleep_entry_a: assert property (sleepDecoded_s |=> sleepEntered_s)
      else $error("sleep not entered after phase four of low-power insn");
   watchdog_clear_a: assert property (sleepDecoded_s |=> clearPulse_s)
      else $error("watchdog clear pulse missing on sleep entry");
   powerdown_clear_a: assert property ($fell(powerdown_flag) |->
      $rose(sleeping))
      else $error("power-down flag cleared without sleep entry");
   watchdog_wake_a: assert property (sleeping && wakeEvent &&
      wakeWatchdog |=> !timeout_flag && !sleeping)
      else $error("watchdog wake did not clear time-out flag");
   sleep_phase_a: assert property ($rose(sleeping) |->
      $past(phase_r) == PH_Q4)
      else $error("sleep entered outside phase four");
   dest_write_a: assert property (fileWrEn |->
      $past(insn_r[DEST_BIT]) && $past(phase_r) == PH_Q4)
      else $error("file write without dest select set");
   acc_hold_a: assert property (fileWrEn |-> $stable(accOut))
      else $error("accumulator changed on file-destination subtract");
   // flags are held against the result of the cycle that made them, since
   // the live difference moves on once the accumulator is written
   sub_result_a: assert property (phase_r == PH_Q4 && isSubb_r |=>
      zeroFlag == ($past(res) == 8'h00) && negFlag == $past(res[7])
      && carryFlag == !$past(diff[8]) && overflow_flag == $past(ovNxt)
      && digit_carry_flag == !$past(lowDiff[4]))
      else $error("subtract flags wrong");
   bank_addr_a: assert property (phase_r == PH_Q2 && isSubb_r &&
      bankSel |=> fileAddr == {$past(bank_select_reg), $past(fOff)})
      else $error("banked address not taken from bank select");
   indexed_addr_a: assert property (phase_r == PH_Q2 && isSubb_r &&
      !bankSel && extendedEn && fOff <= INDEXED_MAX |=>
      fileAddr[11:8] == 4'h0)
      else $error("indexed address left the low bank");
endmodule
`default_nettype wire

// ### sim/sleep_and_borrow_subtract_exec_tb.sv
/*
 * self-checking bench for the low-power entry and borrow-subtract block.
 * assumes exec_pkg is compiled first; the design guards itself with its
 * own assertions, this bench judges results at the ports.
 */
`default_nettype none
module sleep_and_borrow_subtract_exec_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import exec_pkg::*;
   logic              ref_clk = 1'b0, reset = 1'b1;
   logic [15:0]       insnWord = 16'h0000;
   logic              insnValid = 1'b0, extendedEn = 1'b0;
   logic [7:0]        fileData = 8'h00, indexBase = 8'h00;
   logic [3:0]        bankSel = 4'h0;
   logic              wakeEvent = 1'b0, wakeWatchdog = 1'b0;
   logic [7:0]        accOut, fileWrData;
   logic [11:0]       fileAddr;
   logic              fileWrEn, timeoutFlag, powerdownFlag, carryFlag;
   logic              digitCarry, zeroFlag, overflowFlag, negFlag;
   logic              watchdogClr, oscHalt, sleeping;
   int                num_errors = 0, comparisons = 0, cycles = 0;
   int                wrPulses, clrPulses;
   logic [7:0]        accModel = 8'h00;
   logic              cModel = 1'b0;
   sleep_and_borrow_subtract_exec dut (.ref_clk(ref_clk), .reset(reset),
      .insnWord(insnWord), .insnValid(insnValid), .fileData(fileData),
      .bank_select_reg(bankSel), .extendedEn(extendedEn),
      .indexBase(indexBase), .wakeEvent(wakeEvent),
      .wakeWatchdog(wakeWatchdog), .accOut(accOut), .fileAddr(fileAddr),
      .fileWrData(fileWrData), .fileWrEn(fileWrEn),
      .timeout_flag(timeoutFlag), .powerdown_flag(powerdownFlag),
      .carryFlag(carryFlag), .digit_carry_flag(digitCarry),
      .zeroFlag(zeroFlag), .overflow_flag(overflowFlag),
      .negFlag(negFlag), .watchdogClr(watchdogClr), .oscHalt(oscHalt),
      .sleeping(sleeping));
   ////////////////////////////////////////////////////////////////////////
   // clock, hang guard and pulse counters
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (fileWrEn === 1'b1) wrPulses++;
      if (watchdogClr === 1'b1) clrPulses++;
      if (cycles == 5000) begin // far above the roughly 125 cycles needed
         num_errors++;
         complete_run();
      end
   end
   task automatic check(input logic [11:0] seen, input logic [11:0] want);
      comparisons++;
      if (seen !== want) begin
         num_errors++;
         $display("BAD %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // word held valid for four edges so exactly one phase-one edge takes it;
   // the bench needs no knowledge of the phase counter this way
   task automatic op(input logic [15:0] w, input logic [7:0] fd);
      @(posedge ref_clk);
      wrPulses = 0;
      clrPulses = 0;
      insnWord <= w;
      insnValid <= 1'b1;
      fileData <= fd;
      repeat (4) @(posedge ref_clk);
      insnValid <= 1'b0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic sub_check(input logic d, a, ext, input logic [3:0] bnk,
                            input logic [7:0] idx, f, fd,
                            input logic [11:0] wantAddr);
      logic [8:0] full;
      logic [4:0] low;
      logic [7:0] res;
      logic       ovf;
      full = {1'b0, accModel} - {1'b0, fd} - {8'h00, ~cModel};
      low = {1'b0, accModel[3:0]} - {1'b0, fd[3:0]} - {4'h0, ~cModel};
      res = full[7:0];
      ovf = (accModel[7] != fd[7]) && (res[7] != accModel[7]);
      // operand setup lands on a rising edge, ahead of the word itself
      @(posedge ref_clk);
      extendedEn <= ext;
      bankSel <= bnk;
      indexBase <= idx;
      op({SUBB_OPC, d, a, f}, fd);
      check(fileAddr, wantAddr);
      check(12'({negFlag, overflowFlag, carryFlag, digitCarry, zeroFlag}),
            12'({res[7], ovf, ~full[8], ~low[4], res == 8'h00}));
      check(12'(wrPulses), {11'h000, d});
      check(12'(clrPulses), 12'h000);
      if (d) check(12'(fileWrData), 12'(res));
      else accModel = res;
      check(12'(accOut), 12'(accModel));
      cModel = ~full[8];
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      @(negedge ref_clk);
      check({timeoutFlag, powerdownFlag, sleeping, oscHalt, accOut},
            12'hC00);
   endtask
   task automatic t_subtract();
      logic [11:0] addrs [5] = '{12'h534, 12'hF70, 12'h020, 12'h030, 12'hF60};
      logic [7:0]  fs [5] = '{8'h34, 8'h70, 8'h20, 8'h20, 8'h60};
      logic [7:0]  fds [5] = '{8'h02, 8'h7C, 8'h7E, 8'h7F, 8'h01};
      logic [4:0]  dae [5] = '{5'b10000, 5'b01000, 5'b00000, 5'b00100,
                               5'b00100};
      for (int i = 0; i < 5; i++) begin
         sub_check(dae[i][3], dae[i][4], dae[i][2], 4'h5, 8'h10, fs[i],
                   fds[i], addrs[i]);
      end
   endtask
   task automatic wake(input logic wd);
      @(posedge ref_clk);
      wakeEvent <= 1'b1;
      wakeWatchdog <= wd;
      @(posedge ref_clk);
      wakeEvent <= 1'b0;
      wakeWatchdog <= 1'b0;
      @(negedge ref_clk);
      check(12'({sleeping, oscHalt, timeoutFlag}), 12'({2'b00, ~wd}));
   endtask
   task automatic t_sleep();
      for (int k = 0; k < 3; k++) begin
         op(SLEEP_WORD, 8'h00);
         check(12'({sleeping, oscHalt, timeoutFlag, powerdownFlag}),
               12'h00E);
         check(12'(clrPulses), 12'h001);
         // a subtract offered while asleep must leave the core untouched
         op({SUBB_OPC, 2'b01, 8'h10}, 8'h11);
         check(12'({sleeping, accOut}), 12'({1'b1, accModel}));
         check(12'(wrPulses), 12'h000);
         wake(k[0]);
      end
      sub_check(1'b0, 1'b1, 1'b0, 4'h2, 8'h00, 8'h05, 8'h03, 12'h205);
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_subtract();
      t_sleep();
      complete_run();
   end
endmodule
`default_nettype wire
